// ---- dv/mdm_phy_model.sv ----
// behavioural phy answering frames on the shared management bus
`timescale 1ns/1ps
`default_nettype none

module mdm_phy_model #(
  parameter logic [4:0] ADDR = 5'h00
) (
  input wire logic mdc,
  input wire logic mdio,
  output logic phy_oe,
  output logic phy_out
);
  logic [15:0] mem [0:31];
  logic [13:0] hdr = 14'h0000;
  logic [15:0] sr = 16'h0000;
  int pre = 0;
  int pos = 0;
  wire logic hit;
  wire logic is_rd;
  wire logic is_wr;

  assign hit = hdr[9:5] == ADDR;
  assign is_rd = hit && hdr[11:10] == 2'h2;
  assign is_wr = hit && hdr[11:10] == 2'h1;

  initial begin
    phy_oe = 1'b0;
    phy_out = 1'b1;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'h0000;
    end
  end

  always @(posedge mdc) begin
    sr <= {sr[14:0], mdio};
    if (pos == 0) begin
      pre <= mdio ? pre + 1 : 0;
      if (!mdio && pre >= 32) begin
        pos <= 1;
        hdr <= 14'h0000;
      end
    end else begin
      hdr <= (pos < 14) ? {hdr[12:0], mdio} : hdr;
      pos <= (pos == 31) ? 0 : pos + 1;
      if (pos == 31 && is_wr) begin
        mem[hdr[4:0]] <= {sr[14:0], mdio};
      end
    end
  end

  // idle ta bit, zero, then data
  always @(negedge mdc) begin
    phy_oe <= is_rd && pos >= 15 && pos <= 31;
    phy_out <= (pos == 15) ? 1'b0 : mem[hdr[4:0]][4'(31 - pos)];
  end
endmodule : mdm_phy_model

`default_nettype wire

// ---- dv/test_phy_management_serial_frames.sv ----
// self-checking bench of the management frame master
`timescale 1ns/1ps
`default_nettype none
`include "mdm_map.svh"

module test_phy_management_serial_frames;
  logic clk_sys, rstn, ce, user_start, user_read, user_phy_sel, user_irq_mask_set, user_irq_clear;
  logic link_irq_enable, link_irq_clear;
  logic [4:0] phy_addr_0, phy_addr_1, user_reg_addr, monitored_phy_address;
  logic [15:0] user_wdata, rd_data;
  logic go_busy, rd_valid, user_access_done_irq, user_irq_masked_status, link_change_irq;
  logic link_irq_masked_status, mgmt_serial_clock, mdio_out, mdio_oe;
  logic p0_oe, p0_out, p1_oe, p1_out, mdio_wire;
  logic [63:0] cap = 64'h0;
  int n_fail, n_checks, n_rdv, n_uirq, n_lirq, n_bits, n_clash;

  mdm_master DUT (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .user_start(user_start),
    .user_read(user_read), .user_phy_sel(user_phy_sel), .phy_addr_0(phy_addr_0),
    .phy_addr_1(phy_addr_1), .user_reg_addr(user_reg_addr), .user_wdata(user_wdata),
    .go_busy(go_busy), .rd_data(rd_data), .rd_valid(rd_valid),
    .user_irq_mask_set(user_irq_mask_set), .user_irq_clear(user_irq_clear),
    .user_access_done_irq(user_access_done_irq), .user_irq_masked_status(user_irq_masked_status),
    .monitored_phy_address(monitored_phy_address), .link_irq_enable(link_irq_enable),
    .link_irq_clear(link_irq_clear), .link_change_irq(link_change_irq),
    .link_irq_masked_status(link_irq_masked_status), .mgmt_serial_clock(mgmt_serial_clock),
    .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  mdm_phy_model #(.ADDR(5'h03)) phy0 (.mdc(mgmt_serial_clock), .mdio(mdio_wire), .phy_oe(p0_oe), .phy_out(p0_out));
  mdm_phy_model #(.ADDR(5'h1C)) phy1 (.mdc(mgmt_serial_clock), .mdio(mdio_wire), .phy_oe(p1_oe), .phy_out(p1_out));

  // pull-up holds a released line high
  assign mdio_wire = mdio_oe ? mdio_out : p0_oe ? p0_out : p1_oe ? p1_out : 1'b1;

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    n_rdv <= n_rdv + 32'(rd_valid === 1'b1);
    n_uirq <= n_uirq + 32'(user_access_done_irq === 1'b1);
    n_lirq <= n_lirq + 32'(link_change_irq === 1'b1);
    n_clash <= n_clash + 32'(mdio_oe === 1'b1 && (p0_oe || p1_oe));
  end

  always @(posedge mgmt_serial_clock) begin
    cap <= {cap[62:0], mdio_wire};
    n_bits <= n_bits + 1;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (go_busy !== lvl && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 2000) begin
      n_fail++;
      complete_run();
    end
  endtask : wait_busy

  // one whole frame; poke tries a second request while busy
  task automatic frame(input logic rd, input logic sel, input logic [4:0] ra, input logic [15:0] wd,
                       input logic poke);
    @(negedge clk_sys);
    n_bits = 0;
    user_start = 1'b1;
    user_read = rd;
    user_phy_sel = sel;
    user_reg_addr = ra;
    user_wdata = wd;
    @(negedge clk_sys);
    user_start = 1'b0;
    wait_busy(1'b1);
    repeat (30) @(negedge clk_sys);
    user_start = poke;
    user_read = 1'b1;
    @(negedge clk_sys);
    user_start = 1'b0;
    wait_busy(1'b0);
    repeat (3) @(negedge clk_sys);
  endtask : frame

  task automatic t_write;
    frame(1'b0, 1'b0, 5'h11, 16'hA5C3, 1'b1);
    check(cap, {32'hFFFF_FFFF, 2'h1, 2'h1, 5'h03, 5'h11, 2'h2, 16'hA5C3});
    check(n_bits, 64);
    repeat (40) @(negedge clk_sys);
    check({go_busy, mdio_oe, mdio_wire, mgmt_serial_clock, n_uirq}, {4'h2, 32'h0});
    $display("write test done");
  endtask : t_write

  // ce low mid-frame must stop the management clock, then the frame resumes intact
  task automatic t_freeze;
    int held;
    @(negedge clk_sys);
    n_bits = 0;
    user_start = 1'b1;
    user_read = 1'b0;
    user_phy_sel = 1'b0;
    user_reg_addr = 5'h05;
    user_wdata = 16'h1234;
    @(negedge clk_sys);
    user_start = 1'b0;
    repeat (100) @(negedge clk_sys);
    ce = 1'b0;
    held = n_bits;
    repeat (50) @(negedge clk_sys);
    check(n_bits, held);
    ce = 1'b1;
    wait_busy(1'b0);
    repeat (3) @(negedge clk_sys);
    check(cap, {32'hFFFF_FFFF, 2'h1, 2'h1, 5'h03, 5'h05, 2'h2, 16'h1234});
    check(n_bits, 64);
    $display("freeze test done");
  endtask : t_freeze

  task automatic t_read;
    frame(1'b0, 1'b1, 5'h07, 16'h3C5A, 1'b0);
    user_irq_mask_set = 1'b1;
    frame(1'b1, 1'b1, 5'h07, 16'h0000, 1'b0);
    check(cap, {32'hFFFF_FFFF, 2'h1, 2'h2, 5'h1C, 5'h07, 2'h2, 16'h3C5A});
    check(rd_data, 16'h3C5A);
    check({n_rdv[7:0], n_uirq[7:0], user_irq_masked_status, mdio_oe, mdio_wire}, {8'h1, 8'h1, 3'h5});
    user_irq_clear = 1'b1;
    @(negedge clk_sys);
    user_irq_clear = 1'b0;
    user_irq_mask_set = 1'b0;
    @(negedge clk_sys);
    check({user_irq_masked_status, n_clash}, 33'h0);
    $display("read test done");
  endtask : t_read

  task automatic t_link;
    monitored_phy_address = 5'h1C;
    link_irq_enable = 1'b1;
    frame(1'b0, 1'b0, `MDM_REG_LINK, 16'h0004, 1'b0);
    frame(1'b1, 1'b0, `MDM_REG_LINK, 16'h0000, 1'b0);
    check({rd_data, n_lirq[7:0]}, {16'h0004, 8'h0});
    frame(1'b0, 1'b1, `MDM_REG_LINK, 16'h0004, 1'b0);
    frame(1'b1, 1'b1, `MDM_REG_LINK, 16'h0000, 1'b0);
    check({n_lirq[7:0], link_irq_masked_status}, {8'h1, 1'b1});
    frame(1'b1, 1'b1, `MDM_REG_LINK, 16'h0000, 1'b0);
    link_irq_clear = 1'b1;
    @(negedge clk_sys);
    link_irq_clear = 1'b0;
    link_irq_enable = 1'b0;
    frame(1'b0, 1'b1, `MDM_REG_LINK, 16'h0000, 1'b0);
    frame(1'b1, 1'b1, `MDM_REG_LINK, 16'h0000, 1'b0);
    check({n_lirq[7:0], link_irq_masked_status, n_uirq[7:0]}, {8'h1, 1'b0, 8'h1});
    $display("link test done");
  endtask : t_link

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    user_start = 1'b0;
    user_read = 1'b0;
    user_phy_sel = 1'b0;
    user_irq_mask_set = 1'b0;
    user_irq_clear = 1'b0;
    link_irq_enable = 1'b0;
    link_irq_clear = 1'b0;
    phy_addr_0 = 5'h03;
    phy_addr_1 = 5'h1C;
    user_reg_addr = 5'h00;
    monitored_phy_address = 5'h00;
    user_wdata = 16'h0000;
    repeat (20) @(negedge clk_sys);
    check({go_busy, mdio_oe, mdio_out, mgmt_serial_clock, rd_data}, {4'h2, 16'h0000});
    rstn = 1'b1;
    t_write();
    t_freeze();
    t_read();
    t_link();
    complete_run();
  end
endmodule : test_phy_management_serial_frames

`default_nettype wire

// ---- hdl/mdm_clkdiv.sv ----
// management clock divider with edge strobes
`timescale 1ns/1ps
`default_nettype none
`include "mdm_map.svh"

module mdm_clkdiv (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  mdm_tick_if.gen tick
);

  logic [7:0] cnt;
  logic level;
  wire tick_end = tick.run && ce && (cnt == 8'(`MDM_MDC_HALF_CYC - 1));

  assign tick.rise = tick_end && !level;
  assign tick.fall = tick_end && level;
  assign tick.level = level;

  // clock rests low and stops outside frames
  always_ff @(posedge clk_sys) begin
    if (!rstn || (ce && !tick.run)) begin
      cnt <= 8'h00;
      level <= 1'b0;
    end else if (ce) begin
      cnt <= tick_end ? 8'h00 : cnt + 8'h01;
      level <= tick_end ? !level : level;
    end
  end

endmodule : mdm_clkdiv

`default_nettype wire

// ---- hdl/mdm_master.sv ----
// station-management serial frame master for two phys
// Function
// RULE_01: with no frame in progress the data line is released and rests high.
// RULE_02: every frame opens with 32 one bits over 32 management clock cycles.
// RULE_03: a phy answers only after it has seen that 32-bit preamble.
// RULE_04: the preamble is followed by the start pattern zero then one.
// RULE_05: the opcode follows, binary 10 for read and binary 01 for write.
// RULE_06: a 5-bit phy address follows, most significant bit first.
// RULE_07: a 5-bit register address follows, most significant bit first.
// RULE_08: in a read the first turnaround bit is driven by nobody.
// RULE_09: in a read the phy drives zero in the second turnaround bit.
// RULE_10: in a write the master drives the turnaround as one then zero.
// RULE_11: the 16 data bits go most significant first, phy drives reads, master writes.
// RULE_12: the engine reaches two phys over the one shared clock and data pair.
// RULE_13: one bit per management clock, driven at the fall and read back at the rise.
// RULE_14: a finished read keeps its 16 data bits and releases the data line.
// RULE_15: when busy falls and the user mask is set the user interrupt fires and is recorded.
// RULE_16: a link change of the monitored phy raises the link interrupt when enabled.
`timescale 1ns/1ps
`default_nettype none
`include "mdm_map.svh"

module mdm_master import mdm_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire logic user_start,
  input wire logic user_read,
  input wire logic user_phy_sel,
  input wire logic [4:0] phy_addr_0,
  input wire logic [4:0] phy_addr_1,
  input wire logic [4:0] user_reg_addr,
  input wire logic [15:0] user_wdata,
  output logic go_busy,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic user_irq_mask_set,
  input wire logic user_irq_clear,
  output logic user_access_done_irq,
  output logic user_irq_masked_status,
  input wire logic [4:0] monitored_phy_address,
  input wire logic link_irq_enable,
  input wire logic link_irq_clear,
  output logic link_change_irq,
  output logic link_irq_masked_status,
  output logic mgmt_serial_clock,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe
);

  mdm_tick_if tick ();
  mdm_state_t state;
  logic [5:0] bit_idx;
  logic [63:0] frame_sr;
  logic [15:0] rd_sr;
  logic [4:0] cur_phy;
  logic [4:0] cur_reg;
  logic [15:0] cur_wdata;
  logic cur_read;
  logic mdio_meta;
  logic mdio_sync;
  logic go_prev;
  logic link_state;

  mdm_clkdiv u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .tick(tick)
  );

  // RULE_12 two phys
  wire [4:0] sel_phy = user_phy_sel ? phy_addr_1 : phy_addr_0;
  wire take = ce && user_start && (state == MDM_ST_IDLE);
  wire [1:0] sel_op = user_read ? `MDM_OP_RD : `MDM_OP_WR;
  wire [1:0] sel_ta = user_read ? `MDM_TA_RD : `MDM_TA_WR;
  wire [15:0] sel_data = user_read ? `MDM_RD_FILL : user_wdata;
  // RULE_04 RULE_05 start and opcode
  // RULE_06 RULE_07 address fields, msb first
  // RULE_10 RULE_11 turnaround and data
  // RULE_02 preamble first
  wire [63:0] next_frame = {`MDM_PREAMBLE, `MDM_START, sel_op, sel_phy, user_reg_addr, sel_ta, sel_data};
  wire in_frame = (state == MDM_ST_FRAME);
  wire frame_end = in_frame && tick.fall && (bit_idx == `MDM_BIT_LAST);
  wire [5:0] next_bit = bit_idx + 6'h01;
  // RULE_13 capture at rise
  wire capture = in_frame && tick.rise && cur_read && (bit_idx >= `MDM_BIT_DAT);
  wire go_fall = go_prev && !go_busy;
  // RULE_16 link bit of monitored phy
  wire link_seen = rd_sr[`MDM_LINK_POS];
  wire link_evt = frame_end && cur_read && (cur_phy == monitored_phy_address) && (cur_reg == `MDM_REG_LINK)
    && (link_seen != link_state);

  assign tick.run = in_frame;
  assign mgmt_serial_clock = tick.level;

  // pin input, second flop alone reads the first
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mdio_meta <= 1'b1;
      mdio_sync <= 1'b1;
    end else if (ce) begin
      mdio_meta <= mdio_in;
      mdio_sync <= mdio_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= MDM_ST_IDLE;
      bit_idx <= 6'h00;
      frame_sr <= 64'hFFFF_FFFF_FFFF_FFFF;
      cur_phy <= 5'h00;
      cur_reg <= 5'h00;
      cur_wdata <= 16'h0000;
      cur_read <= 1'b0;
      go_busy <= 1'b0;
    end else if (ce) begin
      case (state)
        MDM_ST_IDLE: begin
          if (take) begin
            state <= MDM_ST_FRAME;
            bit_idx <= 6'h00;
            frame_sr <= next_frame;
            cur_phy <= sel_phy;
            cur_reg <= user_reg_addr;
            cur_wdata <= user_wdata;
            cur_read <= user_read;
            go_busy <= 1'b1;
          end
        end
        MDM_ST_FRAME: begin
          // RULE_13 one bit per fall
          if (frame_end) begin
            state <= MDM_ST_IDLE;
            frame_sr <= 64'hFFFF_FFFF_FFFF_FFFF;
            go_busy <= 1'b0;
          end else if (tick.fall) begin
            bit_idx <= next_bit;
            frame_sr <= {frame_sr[62:0], 1'b1};
          end
        end
        default: state <= MDM_ST_IDLE;
      endcase
    end
  end

  // RULE_01 released when idle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mdio_oe <= 1'b0;
    end else if (ce) begin
      if (take) begin
        mdio_oe <= 1'b1;
      end else if (frame_end) begin
        mdio_oe <= 1'b0;
      // RULE_08 read turnaround undriven
      end else if (in_frame && tick.fall && cur_read && (next_bit == `MDM_BIT_TA)) begin
        mdio_oe <= 1'b0;
      end
    end
  end

  assign mdio_out = frame_sr[63];

  // RULE_14 keep read data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rd_sr <= 16'h0000;
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= frame_end && cur_read;
      if (capture) begin
        rd_sr <= {rd_sr[14:0], mdio_sync};
      end
      if (frame_end && cur_read) begin
        rd_data <= rd_sr;
      end
    end
  end

  // RULE_15 busy fall, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      go_prev <= 1'b0;
      user_access_done_irq <= 1'b0;
      user_irq_masked_status <= 1'b0;
    end else if (ce) begin
      go_prev <= go_busy;
      user_access_done_irq <= go_fall && user_irq_mask_set;
      user_irq_masked_status <= (go_fall && user_irq_mask_set) || (user_irq_masked_status && !user_irq_clear);
    end
  end

  // RULE_16 link change event
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      link_state <= 1'b0;
      link_change_irq <= 1'b0;
      link_irq_masked_status <= 1'b0;
    end else if (ce) begin
      if (link_evt) begin
        link_state <= link_seen;
      end
      link_change_irq <= link_evt && link_irq_enable;
      link_irq_masked_status <= (link_evt && link_irq_enable) || (link_irq_masked_status && !link_irq_clear);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  wire [5:0] phy_rel = `MDM_BIT_PHY_LAST - bit_idx;
  wire [5:0] reg_rel = `MDM_BIT_REG_LAST - bit_idx;
  wire [5:0] dat_rel = `MDM_BIT_LAST - bit_idx;

  sequence s_go_fall;
    $fell(go_busy) ##0 (user_irq_mask_set && ce);
  endsequence
  sequence s_rd_done;
    $fell(go_busy) ##0 cur_read;
  endsequence

  property p_idle_release;
    state == MDM_ST_IDLE |-> !mdio_oe && !mgmt_serial_clock;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("bus not released in idle"); // RULE_01
  property p_preamble;
    in_frame && bit_idx < `MDM_BIT_ST |-> mdio_oe && mdio_out;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bit not driven one"); // RULE_02
  property p_start;
    in_frame && bit_idx == `MDM_BIT_ST ##1 in_frame && bit_idx == `MDM_BIT_ST + 6'h01 |-> mdio_out && !$past(mdio_out);
  endproperty
  a_start: assert property (p_start) else $error("start pattern wrong"); // RULE_04
  property p_opcode;
    in_frame && bit_idx == `MDM_BIT_OP |-> mdio_out == cur_read && mdio_oe;
  endproperty
  a_opcode: assert property (p_opcode) else $error("opcode first bit wrong"); // RULE_05
  property p_phy_addr;
    in_frame && bit_idx >= `MDM_BIT_PHY && bit_idx <= `MDM_BIT_PHY_LAST |-> mdio_out == cur_phy[phy_rel[2:0]];
  endproperty
  a_phy_addr: assert property (p_phy_addr) else $error("phy address bit wrong"); // RULE_06
  property p_reg_addr;
    in_frame && bit_idx >= `MDM_BIT_REG && bit_idx <= `MDM_BIT_REG_LAST |-> mdio_out == cur_reg[reg_rel[2:0]];
  endproperty
  a_reg_addr: assert property (p_reg_addr) else $error("register address bit wrong"); // RULE_07
  property p_rd_ta;
    in_frame && cur_read && bit_idx >= `MDM_BIT_TA |-> !mdio_oe;
  endproperty
  a_rd_ta: assert property (p_rd_ta) else $error("master drives during read turnaround"); // RULE_08
  property p_wr_ta;
    in_frame && !cur_read && bit_idx == `MDM_BIT_TA |-> mdio_oe && mdio_out;
  endproperty
  a_wr_ta: assert property (p_wr_ta) else $error("write turnaround not one"); // RULE_10
  property p_wr_data;
    in_frame && !cur_read && bit_idx >= `MDM_BIT_DAT |-> mdio_oe && mdio_out == cur_wdata[dat_rel[3:0]];
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data bit wrong"); // RULE_11
  property p_bit_on_fall;
    in_frame && $past(state) == MDM_ST_FRAME && $changed(bit_idx) |-> $fell(mgmt_serial_clock);
  endproperty
  a_bit_on_fall: assert property (p_bit_on_fall) else $error("bit advanced off the falling edge"); // RULE_13
  property p_rd_done;
    s_rd_done |-> !mdio_oe && rd_data == $past(rd_sr);
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read end not stored or not released"); // RULE_14
  property p_user_irq;
    s_go_fall |=> user_access_done_irq && user_irq_masked_status;
  endproperty
  a_user_irq: assert property (p_user_irq) else $error("user interrupt missing"); // RULE_15
  property p_link_irq;
    link_evt && link_irq_enable && ce |=> link_change_irq && link_irq_masked_status;
  endproperty
  a_link_irq: assert property (p_link_irq) else $error("link interrupt missing"); // RULE_16

endmodule : mdm_master

`default_nettype wire

// ---- inc/mdm_map.svh ----
// constants of the station-management serial engine
`ifndef MDM_MAP_SVH
`define MDM_MAP_SVH

// system clock and least management clock half period, in ns
`define MDM_CLK_NS 25
`define MDM_MDC_HALF_NS 200
// least time rounds up to whole system clock cycles
`define MDM_MDC_HALF_CYC ((`MDM_MDC_HALF_NS + `MDM_CLK_NS - 1) / `MDM_CLK_NS)

// frame bit positions, bit 0 is the first preamble bit
`define MDM_BIT_ST 6'h20
`define MDM_BIT_OP 6'h22
`define MDM_BIT_PHY 6'h24
`define MDM_BIT_PHY_LAST 6'h28
`define MDM_BIT_REG 6'h29
`define MDM_BIT_REG_LAST 6'h2D
`define MDM_BIT_TA 6'h2E
`define MDM_BIT_DAT 6'h30
`define MDM_BIT_LAST 6'h3F

// frame field values
`define MDM_PREAMBLE 32'hFFFF_FFFF
`define MDM_START 2'h1
`define MDM_OP_RD 2'h2
`define MDM_OP_WR 2'h1
`define MDM_TA_WR 2'h2
`define MDM_TA_RD 2'h3
`define MDM_RD_FILL 16'hFFFF

// phy status register and its link bit
`define MDM_REG_LINK 5'h01
`define MDM_LINK_POS 2

`endif

// ---- inc/mdm_pkg.sv ----
// types of the station-management serial engine
package mdm_pkg;

  typedef enum logic [1:0] {
    MDM_ST_IDLE = 2'h1,
    MDM_ST_FRAME = 2'h2
  } mdm_state_t;

endpackage : mdm_pkg

// ---- inc/mdm_tick_if.sv ----
// management clock strobes between frame engine and divider
`timescale 1ns/1ps
`default_nettype none

interface mdm_tick_if;
  logic run;
  logic rise;
  logic fall;
  logic level;

  modport ctl (output run, input rise, input fall, input level);
  modport gen (input run, output rise, output fall, output level);
endinterface : mdm_tick_if

`default_nettype wire
